// File: rtl/dbg_ctl_pkg.sv
// Package with register map, field positions, encodings and reset values
package dbg_ctl_pkg;
    // Register indices (word indices; the byte address is four times the index)
    localparam logic [7:0] IDX_DEBUG_CONTROL_ONE    = 8'h20;
    localparam logic [7:0] IDX_DEBUG_STATUS         = 8'h21;
    localparam logic [7:0] IDX_TRACE_CONTROL        = 8'h22;
    localparam logic [7:0] IDX_COMPARATOR_MATCH_CTL = 8'h23;
    localparam logic [7:0] IDX_TRACE_COUNT          = 8'h26;
    localparam logic [7:0] IDX_SEQ_WINDOW           = 8'h27;
    localparam logic [7:0] IDX_BANK_SELECT_VIEW     = 8'h28;
    localparam int         ADDR_W                   = 10;
    // Field positions
    localparam int ARM_BIT       = 7;
    localparam int TRIG_BIT      = 6;
    localparam int BDM_BIT       = 4;
    localparam int BRK_BIT       = 3;
    localparam int FULL_BIT      = 7;
    localparam int SOURCE_BIT    = 6;
    localparam int MODE_HI       = 3;
    localparam int MODE_LO       = 2;
    localparam int ALIGN_BIT     = 0;
    // Trace depth
    localparam logic [6:0] TRACE_LINES = 7'h40;
    // Reset values
    localparam logic [7:0] RESET_BYTE  = 8'h00;
    // Sequencer state encoding
    typedef enum logic [2:0] {
        SEQ_DISARMED = 3'b000,
        SEQ_STATE1   = 3'b001,
        SEQ_STATE2   = 3'b010,
        SEQ_STATE3   = 3'b011,
        SEQ_FINAL    = 3'b100
    } seq_state_t;
    // Trace modes
    localparam logic [1:0] MODE_NORMAL  = 2'h0;
    localparam logic [1:0] MODE_LOOP    = 2'h1;
    localparam logic [1:0] MODE_DETAIL  = 2'h2;
    localparam logic [1:0] MODE_PC      = 2'h3;
    // Match mapping codes
    localparam logic [1:0] MAP_DIRECT   = 2'h0;
    localparam logic [1:0] MAP_INSIDE   = 2'h1;
    localparam logic [1:0] MAP_OUTSIDE  = 2'h2;
    localparam logic [1:0] MAP_RESERVED = 2'h3;
endpackage

// File: rtl/match_mapper.sv
// Comparator A/B match mapping onto match zero and match one
module match_mapper (
    input  wire logic       clk_sys,
    input  wire logic       reset_n,
    input  wire logic [1:0] match_mapping,
    input  wire logic       comp_a_match,
    input  wire logic       comp_b_match,
    input  wire logic       addr_above_a,
    input  wire logic       addr_below_b,
    output logic            match_zero_r,
    output logic            match_one_r
);
    // Range decode from the two bounds
    wire inside_w  = addr_above_a & addr_below_b;
    wire zero_nxt  = (match_mapping == dbg_ctl_pkg::MAP_DIRECT)  ? comp_a_match :
                     (match_mapping == dbg_ctl_pkg::MAP_INSIDE)  ? inside_w :
                     (match_mapping == dbg_ctl_pkg::MAP_OUTSIDE) ? ~inside_w :
                     comp_a_match;
    // Match one only in direct mapping
    wire one_nxt   = (match_mapping == dbg_ctl_pkg::MAP_DIRECT) & comp_b_match;

    // Registered outputs
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            match_zero_r <= 1'b0;
            match_one_r  <= 1'b0;
        end else begin
            match_zero_r <= zero_nxt;
            match_one_r  <= one_nxt;
        end
    end
endmodule

// File: rtl/trace_mode_decoder.sv
// Decodes trace mode and alignment into trace store controls
module trace_mode_decoder (
    input  wire logic       clk_sys,
    input  wire logic       reset_n,
    input  wire logic [1:0] trace_mode,
    input  wire logic       trigger_alignment,
    input  wire logic       tracing_allowed,
    output logic            store_flow_r,
    output logic            suppress_repeat_r,
    output logic            store_access_r,
    output logic            store_pc_r,
    output logic            align_begin_r
);
    // Mode decode, gated by tracing permission; loop mode sets both flow and repeat suppression
    wire flow_w   = tracing_allowed & ((trace_mode == dbg_ctl_pkg::MODE_NORMAL) |
                                       (trace_mode == dbg_ctl_pkg::MODE_LOOP));
    wire loop_w   = tracing_allowed & (trace_mode == dbg_ctl_pkg::MODE_LOOP);
    wire detail_w = tracing_allowed & (trace_mode == dbg_ctl_pkg::MODE_DETAIL);
    wire pc_w     = tracing_allowed & (trace_mode == dbg_ctl_pkg::MODE_PC);

    // Registered controls
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            store_flow_r      <= 1'b0;
            suppress_repeat_r <= 1'b0;
            store_access_r    <= 1'b0;
            store_pc_r        <= 1'b0;
            align_begin_r     <= 1'b0;
        end else begin
            store_flow_r      <= flow_w;
            suppress_repeat_r <= loop_w;
            store_access_r    <= detail_w;
            store_pc_r        <= pc_w;
            align_begin_r     <= trigger_alignment;
        end
    end
endmodule

// File: rtl/debug_status_trace_control.sv
// Debug control, status, trace control and match mapping registers on Wishbone

// Notes on behaviour
// - Bank select picks window bank and 0x27
// - Armed: only arm, trigger, bank select written
// - Full flag after 64 lines since arming
// - Full cleared by arm write or power-on
// - Full flag in status and count bit7
// - Sequencer flags encode disarmed, states, final
// - Flags follow each sequencer state change
// - Software disarm keeps last flags
// - Internal session end clears flags to zero
// - Arming enters state one, flags 001
// - Source write unsecured and disarmed; others disarmed
// - Source enables tracing; secure blocks it
// - Trace buffer readable only with source set
// - Modes 00 flow, 01 flow without repeats
// - Modes 10 accesses, 11 compressed PC
// - Alignment 0 trigger at end, 1 begin
// - Match control writable only when disarmed
// - Map 00: A to zero, B to one
// - Map 01: inside range, one disabled
// - Map 10: outside range, one disabled
// - Map 11: A only, B disabled
module debug_status_trace_control (
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    input  wire logic        por_n,
    // Wishbone classic slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [11:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // System and sequencer interface
    input  wire logic        secured,
    input  wire logic        seq_advance,
    input  wire logic [2:0]  seq_next_state,
    input  wire logic        session_end_event,
    input  wire logic        trace_line_stored,
    input  wire logic [7:0]  seq_reg_one,
    input  wire logic [7:0]  seq_reg_two,
    input  wire logic [7:0]  seq_reg_three,
    input  wire logic [7:0]  match_flags,
    input  wire logic        comp_a_match,
    input  wire logic        comp_b_match,
    input  wire logic        addr_above_a,
    input  wire logic        addr_below_b,
    // Control outputs
    output logic             armed_r,
    output logic             trigger_req_r,
    output logic [1:0]       comparator_bank_select_r,
    output logic             trace_read_enable_r,
    output logic             match_zero_r,
    output logic             match_one_r,
    output logic             store_flow_r,
    output logic             suppress_repeat_r,
    output logic             store_access_r,
    output logic             store_pc_r,
    output logic             align_begin_r
);
    // Register state
    logic [1:0] ctl_hi_r;                 // Breakpoint target and enable bits
    logic       trace_source_enable_r;    // Trace source
    logic [1:0] trace_mode_r;             // Trace mode
    logic       trigger_alignment_r;      // Trigger alignment
    logic [1:0] match_mapping_r;          // Match mapping
    logic [2:0] sequencer_state_flags_r;  // Sequencer flags
    logic       trace_full_flag_r;        // Trace full
    logic [5:0] trace_count_r;            // Line count

    // Byte lane zero carries the data for every index
    function automatic logic [7:0] lane_byte(input logic [31:0] word, input logic [3:0] sel);
        lane_byte = sel[0] ? word[7:0] : 8'h00;
    endfunction

    // Bus decode
    wire        req_w      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire [9:0]  index_w    = wb_adr_i[11:2];
    wire        wr_w       = req_w & wb_we_i & wb_sel_i[0];
    wire [7:0]  wbyte_w    = lane_byte(wb_dat_i, wb_sel_i);
    wire        hit_c1_w   = (index_w == {2'b00, dbg_ctl_pkg::IDX_DEBUG_CONTROL_ONE});
    wire        hit_sr_w   = (index_w == {2'b00, dbg_ctl_pkg::IDX_DEBUG_STATUS});
    wire        hit_tc_w   = (index_w == {2'b00, dbg_ctl_pkg::IDX_TRACE_CONTROL});
    wire        hit_mc_w   = (index_w == {2'b00, dbg_ctl_pkg::IDX_COMPARATOR_MATCH_CTL});
    wire        hit_cnt_w  = (index_w == {2'b00, dbg_ctl_pkg::IDX_TRACE_COUNT});
    wire        hit_seq_w  = (index_w == {2'b00, dbg_ctl_pkg::IDX_SEQ_WINDOW});
    wire        hit_bank_w = (index_w == {2'b00, dbg_ctl_pkg::IDX_BANK_SELECT_VIEW});

    // Control register one writes
    wire        wr_c1_w    = wr_w & hit_c1_w;
    wire        arm_set_w  = wr_c1_w & wbyte_w[dbg_ctl_pkg::ARM_BIT];
    wire        arm_clr_w  = wr_c1_w & ~wbyte_w[dbg_ctl_pkg::ARM_BIT];
    wire        trig_w     = wr_c1_w & wbyte_w[dbg_ctl_pkg::TRIG_BIT];
    // Both trigger and arm written while armed ends the session
    wire        end_by_sw_w = arm_clr_w | (trig_w & wbyte_w[dbg_ctl_pkg::ARM_BIT] & armed_r);
    // Guarded writes: other bits only while disarmed
    wire        wr_c1_lock_w = wr_c1_w & ~armed_r;
    wire        wr_src_w   = wr_w & hit_tc_w & ~armed_r & ~secured;
    wire        wr_mode_w  = wr_w & hit_tc_w & ~armed_r;
    wire        wr_map_w   = wr_w & hit_mc_w & ~armed_r;

    // Visible sequencer register at 0x27
    wire [7:0]  seq_view_w = (comparator_bank_select_r == 2'h0) ? seq_reg_one :
                             (comparator_bank_select_r == 2'h1) ? seq_reg_two :
                             (comparator_bank_select_r == 2'h2) ? seq_reg_three :
                             match_flags;

    // Status image: bits 6:3 read zero
    wire [7:0]  status_w   = {trace_full_flag_r, 4'h0, sequencer_state_flags_r};
    wire [7:0]  count_w    = {trace_full_flag_r, 1'b0, trace_count_r};
    wire [7:0]  c1_w       = {armed_r, 1'b0, 1'b0, ctl_hi_r, 1'b0, comparator_bank_select_r};
    wire [7:0]  tc_w       = {1'b0, trace_source_enable_r, 2'b00, trace_mode_r, 1'b0,
                              trigger_alignment_r};
    wire [7:0]  mc_w       = {6'h00, match_mapping_r};
    wire [7:0]  rd_byte_w  = hit_c1_w   ? c1_w :
                             hit_sr_w   ? status_w :
                             hit_tc_w   ? tc_w :
                             hit_mc_w   ? mc_w :
                             hit_cnt_w  ? count_w :
                             hit_seq_w  ? seq_view_w :
                             hit_bank_w ? {6'h00, comparator_bank_select_r} :
                             8'h00;

    // Internal session end, last trace line and tracing permission
    wire        internal_end_w = armed_r & session_end_event;
    wire        line_full_w    = armed_r & trace_line_stored &
                                 ({1'b0, trace_count_r} == dbg_ctl_pkg::TRACE_LINES - 7'h01);
    wire        tracing_ok_w   = trace_source_enable_r & ~secured;

    // Bus answer: ack one cycle after request, dropped the next
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            wb_ack_o   <= 1'b0;
            wb_dat_o   <= 32'h0000_0000;
        end else begin
            wb_ack_o   <= req_w;
            wb_dat_o   <= req_w ? {24'h000000, rd_byte_w} : 32'h0000_0000;
        end
    end

    // Control register one
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            armed_r                  <= 1'b0;
            ctl_hi_r                 <= 2'b00;
            comparator_bank_select_r <= 2'b00;
            trigger_req_r            <= 1'b0;
        end else begin
            trigger_req_r <= trig_w & ~secured;
            if (wr_c1_w) begin
                comparator_bank_select_r <= wbyte_w[1:0];
            end
            if (wr_c1_lock_w) begin
                ctl_hi_r <= wbyte_w[dbg_ctl_pkg::BDM_BIT:dbg_ctl_pkg::BRK_BIT];
            end
            // Session end wins over arm request
            if (end_by_sw_w | internal_end_w) begin
                armed_r <= 1'b0;
            end else if (arm_set_w) begin
                armed_r <= 1'b1;
            end
        end
    end

    // Trace control and match mapping registers
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            trace_source_enable_r <= 1'b0;
            trace_mode_r          <= dbg_ctl_pkg::MODE_NORMAL;
            trigger_alignment_r   <= 1'b0;
            match_mapping_r       <= dbg_ctl_pkg::MAP_DIRECT;
        end else begin
            if (secured) begin
                trace_source_enable_r <= 1'b0;
            end else if (wr_src_w) begin
                trace_source_enable_r <= wbyte_w[dbg_ctl_pkg::SOURCE_BIT];
            end
            if (wr_mode_w) begin
                trace_mode_r        <= wbyte_w[dbg_ctl_pkg::MODE_HI:dbg_ctl_pkg::MODE_LO];
                trigger_alignment_r <= wbyte_w[dbg_ctl_pkg::ALIGN_BIT];
            end
            if (wr_map_w) begin
                match_mapping_r <= wbyte_w[1:0];
            end
        end
    end

    // Trace buffer read permission
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            trace_read_enable_r <= 1'b0;
        end else begin
            trace_read_enable_r <= trace_source_enable_r & ~armed_r & ~secured;
        end
    end

    // Sequencer flags
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            sequencer_state_flags_r <= dbg_ctl_pkg::SEQ_DISARMED;
        end else if (internal_end_w) begin
            sequencer_state_flags_r <= dbg_ctl_pkg::SEQ_DISARMED;
        end else if (arm_set_w & ~end_by_sw_w & ~armed_r) begin
            sequencer_state_flags_r <= dbg_ctl_pkg::SEQ_STATE1;
        end else if (armed_r & ~end_by_sw_w & seq_advance & ~seq_next_state[2]) begin
            sequencer_state_flags_r <= seq_next_state;
        end else if (armed_r & ~end_by_sw_w & seq_advance) begin
            sequencer_state_flags_r <= dbg_ctl_pkg::SEQ_FINAL;
        end
        // Software disarm leaves flags untouched
    end

    // Trace count and full flag; power-on reset or an arm write clears them, reset_n does not
    always_ff @(posedge clk_sys) begin
        if (!por_n) begin
            trace_full_flag_r <= 1'b0;
            trace_count_r     <= 6'h00;
        end else if (arm_set_w) begin
            trace_full_flag_r <= 1'b0;
            trace_count_r     <= 6'h00;
        end else if (armed_r & trace_line_stored) begin
            trace_count_r <= trace_count_r + 6'h01;
            if (line_full_w) begin
                trace_full_flag_r <= 1'b1;
            end
        end
    end

    // Trace store control decode
    trace_mode_decoder i_trace_mode_decoder (
        .clk_sys           (clk_sys),
        .reset_n           (reset_n),
        .trace_mode        (trace_mode_r),
        .trigger_alignment (trigger_alignment_r),
        .tracing_allowed   (tracing_ok_w),
        .store_flow_r      (store_flow_r),
        .suppress_repeat_r (suppress_repeat_r),
        .store_access_r    (store_access_r),
        .store_pc_r        (store_pc_r),
        .align_begin_r     (align_begin_r)
    );

    // Comparator match mapping
    match_mapper i_match_mapper (
        .clk_sys       (clk_sys),
        .reset_n       (reset_n),
        .match_mapping (match_mapping_r),
        .comp_a_match  (comp_a_match),
        .comp_b_match  (comp_b_match),
        .addr_above_a  (addr_above_a),
        .addr_below_b  (addr_below_b),
        .match_zero_r  (match_zero_r),
        .match_one_r   (match_one_r)
    );
endmodule

// File: sim/dbg_ctl_properties.sv
// Concurrent checks on the bus and control ports of the debug control block
module dbg_ctl_properties (
    input wire logic        clk_sys,
    input wire logic        reset_n,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        secured,
    input wire logic        session_end_event,
    input wire logic        armed_r,
    input wire logic        trigger_req_r,
    input wire logic [1:0]  comparator_bank_select_r,
    input wire logic        trace_read_enable_r
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // Request taken by the slave
    sequence bus_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    // Accepted byte write to control one
    sequence ctl_write;
        bus_take ##0 (wb_we_i && wb_sel_i[0] && wb_adr_i[11:2] == {2'h0, dbg_ctl_pkg::IDX_DEBUG_CONTROL_ONE});
    endsequence
    a_ack_follows: assert property (bus_take |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_idle_data_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data not zero outside ack");
    a_status_bits_zero: assert property (wb_ack_o && !wb_we_i &&
        wb_adr_i[11:2] == {2'h0, dbg_ctl_pkg::IDX_DEBUG_STATUS} |-> wb_dat_o[6:3] == 4'h0 && wb_dat_o[31:8] == 24'h0)
        else $error("status unused bits not zero");
    a_arm_write: assert property (ctl_write ##0 (wb_dat_i[7] && !wb_dat_i[6]) |=> armed_r)
        else $error("arm write did not arm");
    a_disarm_write: assert property (ctl_write ##0 !wb_dat_i[7] |=> !armed_r)
        else $error("disarm write ignored");
    a_trigger_one_pulse: assert property (ctl_write ##0 (wb_dat_i[6] && !wb_dat_i[7] && !secured)
        |=> trigger_req_r ##1 !trigger_req_r)
        else $error("trigger request not a single pulse");
    a_bank_follows: assert property (ctl_write |=> comparator_bank_select_r == $past(wb_dat_i[1:0]))
        else $error("bank select not taken from write");
    a_session_end: assert property (session_end_event && armed_r |=> !armed_r)
        else $error("internal end left block armed");
    a_read_blocked: assert property ((secured || armed_r) |=> !trace_read_enable_r)
        else $error("trace read enabled while secured or armed");
endmodule

bind debug_status_trace_control dbg_ctl_properties i_dbg_ctl_properties (
    .clk_sys(clk_sys), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .secured(secured), .session_end_event(session_end_event), .armed_r(armed_r), .trigger_req_r(trigger_req_r),
    .comparator_bank_select_r(comparator_bank_select_r), .trace_read_enable_r(trace_read_enable_r));

// File: sim/debug_status_trace_control_tb.sv
// Self-checking bench for the debug control, status, trace and match registers
module debug_status_trace_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys, reset_n, por_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [11:0] wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic        secured, seq_advance, session_end_event, trace_line_stored;
    logic [2:0]  seq_next_state;
    logic [7:0]  views [4];                    // Bank-selected view sources
    logic        comp_a_match, comp_b_match, addr_above_a, addr_below_b;
    logic        armed_r, trigger_req_r, trace_read_enable_r, match_zero_r, match_one_r;
    logic [1:0]  comparator_bank_select_r;
    logic        store_flow_r, suppress_repeat_r, store_access_r, store_pc_r, align_begin_r;
    logic [31:0] exp_q [$];                    // Expected read data, oldest first
    int          bad_count, tests_run, cycles, i, j;

    debug_status_trace_control i_debug_status_trace_control (
        .clk_sys(clk_sys), .reset_n(reset_n), .por_n(por_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .secured(secured), .seq_advance(seq_advance), .seq_next_state(seq_next_state),
        .session_end_event(session_end_event), .trace_line_stored(trace_line_stored), .seq_reg_one(views[0]),
        .seq_reg_two(views[1]), .seq_reg_three(views[2]), .match_flags(views[3]), .comp_a_match(comp_a_match),
        .comp_b_match(comp_b_match), .addr_above_a(addr_above_a), .addr_below_b(addr_below_b), .armed_r(armed_r),
        .trigger_req_r(trigger_req_r), .comparator_bank_select_r(comparator_bank_select_r),
        .trace_read_enable_r(trace_read_enable_r), .match_zero_r(match_zero_r), .match_one_r(match_one_r),
        .store_flow_r(store_flow_r), .suppress_repeat_r(suppress_repeat_r), .store_access_r(store_access_r),
        .store_pc_r(store_pc_r), .align_begin_r(align_begin_r));

    // Free-running 250 MHz clock
    initial begin
        clk_sys = 1'h0;
        forever #2 clk_sys = ~clk_sys;
    end

    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    // Verdict and end of run
    task automatic complete_run();
        $display("comparisons %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // One classic Wishbone cycle, held until ack
    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
        @(posedge clk_sys);
        {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'h3, w};
        wb_adr_i <= {2'h0, idx, 2'h0};
        wb_dat_i <= {24'h0, d};
        do @(posedge clk_sys); while (wb_ack_o !== 1'h1);
        {wb_cyc_i, wb_stb_i} <= 2'h0;
    endtask

    // Read with expected byte noted for the monitor
    task automatic rd(input logic [7:0] idx, input logic [7:0] e);
        exp_q.push_back({24'h0, e});
        bus(1'h0, idx, 8'h00);
    endtask

    // Sequencer moves to a new state
    task automatic seq_to(input logic [2:0] st);
        @(posedge clk_sys);
        {seq_advance, seq_next_state} <= {1'h1, st};
        @(posedge clk_sys);
        seq_advance <= 1'h0;
    endtask

    // Stored trace lines, one pulse each
    task automatic lines(input int n);
        for (j = 0; j < n; j++) begin
            @(posedge clk_sys);
            trace_line_stored <= 1'h1;
            @(posedge clk_sys);
            trace_line_stored <= 1'h0;
        end
    endtask

    // Expected match zero and one for a mapping code
    function automatic logic [1:0] exp_map(input logic [1:0] c);
        case (c)
            2'h0: return {comp_a_match, comp_b_match};
            2'h1: return {addr_above_a & addr_below_b, 1'h0};
            2'h2: return {~(addr_above_a & addr_below_b), 1'h0};
            default: return {comp_a_match, 1'h0};
        endcase
    endfunction

    // Read monitor and watchdog
    always @(posedge clk_sys) begin
        if (wb_ack_o === 1'h1 && wb_we_i === 1'h0)
            chk(wb_dat_o, (exp_q.size() > 0) ? exp_q.pop_front() : ~wb_dat_o);
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            complete_run();
        end
    end

    // Main sequence
    initial begin
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, reset_n, por_n} = '0;
        {secured, seq_advance, seq_next_state, session_end_event, trace_line_stored} = '0;
        {comp_a_match, comp_b_match, addr_above_a, addr_below_b} = '0;
        wb_sel_i = 4'h1;
        void'($urandom(32'h405E));
        for (i = 0; i < 4; i++) views[i] = 8'($urandom);
        repeat (20) @(posedge clk_sys);
        {reset_n, por_n} <= 2'h3;
        rd(8'h21, 8'h00);
        bus(1'h1, 8'h21, 8'hFF);
        rd(8'h21, 8'h00);
        rd(8'h30, 8'h00);
        for (i = 0; i < 4; i++) begin
            bus(1'h1, 8'h20, 8'h40 | 8'(i));
            rd(8'h20, 8'(i));
            rd(8'h27, views[i]);
            rd(8'h28, 8'(i));
        end
        for (i = 0; i < 4; i++) begin
            bus(1'h1, 8'h22, {2'h1, 2'h0, 2'(i), 1'h0, 1'(i)});
            rd(8'h22, {2'h1, 2'h0, 2'(i), 1'h0, 1'(i)});
            chk({26'h0, store_flow_r, suppress_repeat_r, store_access_r, store_pc_r, align_begin_r,
                 trace_read_enable_r}, {26'h0, i < 2, i == 1, i == 2, i == 3, 1'(i), 1'h1});
            // Line above also through the store controls
        end
        bus(1'h1, 8'h22, 8'h00);
        secured <= 1'h1;
        bus(1'h1, 8'h22, 8'h44);
        rd(8'h22, 8'h04);
        chk({27'h0, store_flow_r, suppress_repeat_r, store_access_r, store_pc_r, trace_read_enable_r}, 32'h0);
        secured <= 1'h0;
        for (i = 0; i < 4; i++) begin
            bus(1'h1, 8'h23, 8'(i));
            rd(8'h23, 8'(i));
            for (j = 0; j < 6; j++) begin
                @(posedge clk_sys);
                {comp_a_match, comp_b_match, addr_above_a, addr_below_b} <= 4'($urandom);
                repeat (2) @(posedge clk_sys);
                chk({30'h0, match_zero_r, match_one_r}, {30'h0, exp_map(2'(i))});
            end
        end
        bus(1'h1, 8'h20, 8'h80);
        rd(8'h21, 8'h01);
        bus(1'h1, 8'h23, 8'h02);
        rd(8'h23, 8'h03);
        bus(1'h1, 8'h22, 8'h0D);
        rd(8'h22, 8'h04);
        bus(1'h1, 8'h20, 8'h81);
        rd(8'h27, views[1]);
        seq_to(3'h2);
        rd(8'h21, 8'h02);
        seq_to(3'h4);
        rd(8'h21, 8'h04);
        bus(1'h1, 8'h20, 8'h00);
        rd(8'h21, 8'h04);
        chk({31'h0, armed_r}, 32'h0);
        bus(1'h1, 8'h20, 8'h80);
        seq_to(3'h3);
        rd(8'h21, 8'h03);
        @(posedge clk_sys);
        session_end_event <= 1'h1;
        @(posedge clk_sys);
        session_end_event <= 1'h0;
        rd(8'h21, 8'h00);
        chk({31'h0, armed_r}, 32'h0);
        bus(1'h1, 8'h20, 8'h80);
        lines(63);
        rd(8'h26, 8'h3F);
        rd(8'h21, 8'h01);
        lines(1);
        rd(8'h21, 8'h81);
        rd(8'h26, 8'h80);
        @(posedge clk_sys);
        reset_n <= 1'h0;
        repeat (3) @(posedge clk_sys);
        reset_n <= 1'h1;
        rd(8'h21, 8'h80);
        bus(1'h1, 8'h20, 8'h80);
        rd(8'h21, 8'h01);
        rd(8'h26, 8'h00);
        bus(1'h1, 8'h20, 8'hC0);
        rd(8'h21, 8'h01);
        chk({31'h0, armed_r}, 32'h0);
        repeat (3) @(posedge clk_sys);
        complete_run();
    end
endmodule
